// ==== design/eess_top.sv ====
`timescale 1ns/1ps
module eess_top (
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic [3:0]  ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output wire logic [7:0]  RDATA,
	input  wire logic [15:0] EVENT_SRC,
	input  wire logic [7:0]  SHUTDOWN_SRC,
	input  wire logic [3:0]  WAVE,
	output wire logic        START_IMM,
	output wire logic        START_DLY_REQ,
	output wire logic        END_IMM,
	output wire logic        END_DLY_REQ,
	output wire logic        SHUTDOWN,
	output wire logic        PRIMARY_OUTPUT_A,
	output wire logic        OUTPUT_B,
	output wire logic        OUTPUT_C,
	output wire logic        OUTPUT_D,
	output wire logic        OE_N_A,
	output wire logic        OE_N_B,
	output wire logic        OE_N_C,
	output wire logic        OE_N_D
);
	eess_pkg::eess_top_state_type st;
	eess_pkg::eess_top_state_type next_st;
	eess_evt_if                   start_io ();
	eess_evt_if                   end_io ();
	logic [7:0]                   sd_trip;
	logic                         sd_req;
	logic                         start_hit;
	logic                         shut_out;
	logic                         wr_ctrl;

	assign start_io.enable = st.start_en;
	assign start_io.mode   = st.start_mode;
	assign start_io.src    = EVENT_SRC;
	assign end_io.enable   = st.end_en;
	assign end_io.mode     = st.end_mode;
	assign end_io.src      = EVENT_SRC;

	eess_event_detect #(
		.ACTIVE (1'b1)
	) u_start_detect (
		.clk   (CLK),
		.reset (RESET),
		.io    (start_io.det)
	);

	eess_event_detect #(
		.ACTIVE (1'b0)
	) u_end_detect (
		.clk   (CLK),
		.reset (RESET),
		.io    (end_io.det)
	);

	assign start_hit = start_io.edge_hit | start_io.level_hit;

	// Bit 0 pin, 1-4 comparators, 5 logic cell trip low; 7-6 trip high
	assign sd_trip = st.sd_src_en & (st.sd_sample
		^ ~eess_pkg::SD_HIGH_ACTIVE);
	assign sd_req  = |sd_trip;
	assign wr_ctrl = WR && (ADDR == eess_pkg::ADDR_SD_CTRL);

	// Outputs stay overridden after the flag drops, until a start event
	assign shut_out = st.sd_flag | st.override_active;

	function automatic logic [1:0] pin_level(
		input logic [1:0] code,
		input logic       wave,
		input logic       pol,
		input logic       shut
	);
		logic [1:0] res;
		res = {wave ^ pol, 1'b0};
		if (shut) begin
			case (code)
				eess_pkg::OVR_HIGH:     res = 2'b10;
				eess_pkg::OVR_LOW:      res = 2'b00;
				eess_pkg::OVR_TRISTATE: res = 2'b01;
				eess_pkg::OVR_INACTIVE: res = {pol, 1'b0};
				default:                res = 2'b01;
			endcase
		end
		return res;
	endfunction

	always_comb begin
		logic [1:0] lvl;
		lvl     = 2'b00;
		next_st = st;
		next_st.sd_sample = SHUTDOWN_SRC;

		if (WR) begin
			case (ADDR)
				eess_pkg::ADDR_START_EN_LO:   next_st.start_en[7:0] = WDATA;
				eess_pkg::ADDR_START_EN_HI:   next_st.start_en[15:8] = WDATA;
				eess_pkg::ADDR_START_MODE_LO: next_st.start_mode[7:0] = WDATA;
				eess_pkg::ADDR_START_MODE_HI: next_st.start_mode[15:8] = WDATA;
				eess_pkg::ADDR_END_EN_LO:     next_st.end_en[7:0] = WDATA;
				eess_pkg::ADDR_END_EN_HI:     next_st.end_en[15:8] = WDATA;
				eess_pkg::ADDR_END_MODE_LO:   next_st.end_mode[7:0] = WDATA;
				eess_pkg::ADDR_END_MODE_HI:   next_st.end_mode[15:8] = WDATA;
				eess_pkg::ADDR_SD_CTRL: begin
					next_st.auto_restart =
						WDATA[eess_pkg::SD_RESTART_BIT];
					next_st.ovr_bd =
						WDATA[eess_pkg::SD_BD_LSB +: 2];
					next_st.ovr_ac =
						WDATA[eess_pkg::SD_AC_LSB +: 2];
				end
				eess_pkg::ADDR_SD_SRC_EN: next_st.sd_src_en = WDATA;
				eess_pkg::ADDR_POLARITY:  next_st.polarity = WDATA[3:0];
				default: begin
				end
			endcase
		end

		// A live trip wins over a software clear in the same cycle
		if (sd_req) begin
			next_st.sd_flag = 1'b1;
		end else if (wr_ctrl) begin
			next_st.sd_flag = WDATA[eess_pkg::SD_FLAG_BIT];
		end else if (st.auto_restart) begin
			next_st.sd_flag = 1'b0;
		end

		if (st.sd_flag) begin
			next_st.override_active = 1'b1;
		end else if (start_hit) begin
			next_st.override_active = 1'b0;
		end

		next_st.rdata = 8'h00;
		if (RD) begin
			case (ADDR)
				eess_pkg::ADDR_START_EN_LO:   next_st.rdata = st.start_en[7:0];
				eess_pkg::ADDR_START_EN_HI:   next_st.rdata = st.start_en[15:8];
				eess_pkg::ADDR_START_MODE_LO: next_st.rdata = st.start_mode[7:0];
				eess_pkg::ADDR_START_MODE_HI: next_st.rdata = st.start_mode[15:8];
				eess_pkg::ADDR_END_EN_LO:     next_st.rdata = st.end_en[7:0];
				eess_pkg::ADDR_END_EN_HI:     next_st.rdata = st.end_en[15:8];
				eess_pkg::ADDR_END_MODE_LO:   next_st.rdata = st.end_mode[7:0];
				eess_pkg::ADDR_END_MODE_HI:   next_st.rdata = st.end_mode[15:8];
				eess_pkg::ADDR_SD_CTRL: begin
					next_st.rdata = {st.sd_flag, st.auto_restart,
						st.ovr_bd, st.ovr_ac, 2'b00};
				end
				eess_pkg::ADDR_SD_SRC_EN: next_st.rdata = st.sd_src_en;
				eess_pkg::ADDR_POLARITY:  next_st.rdata = {4'h0, st.polarity};
				default:                  next_st.rdata = 8'h00;
			endcase
		end

		// Index 0 is A, 1 is B, 2 is C, 3 is D
		for (int i = 0; i < 4; i++) begin
			lvl = pin_level(i[0] ? st.ovr_bd : st.ovr_ac, WAVE[i],
				st.polarity[i], shut_out);
			next_st.out[i]  = lvl[1];
			next_st.oe_n[i] = lvl[0];
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			st                 <= '0;
			st.start_en        <= eess_pkg::RST_WORD;
			st.start_mode      <= eess_pkg::RST_WORD;
			st.end_en          <= eess_pkg::RST_WORD;
			st.end_mode        <= eess_pkg::RST_WORD;
			st.ovr_bd          <= eess_pkg::RST_OVR_BD;
			st.ovr_ac          <= eess_pkg::RST_OVR_AC;
			st.sd_src_en       <= eess_pkg::RST_BYTE;
			st.polarity        <= eess_pkg::RST_POL;
			st.sd_sample       <= eess_pkg::RST_BYTE;
			st.rdata           <= eess_pkg::RST_BYTE;
		end else begin
			st <= next_st;
		end
	end

	assign RDATA            = st.rdata;
	assign START_IMM        = start_io.level_hit;
	assign START_DLY_REQ    = start_io.edge_hit;
	assign END_IMM          = end_io.level_hit;
	assign END_DLY_REQ      = end_io.edge_hit;
	assign SHUTDOWN         = st.sd_flag;
	assign PRIMARY_OUTPUT_A = st.out[0];
	assign OUTPUT_B         = st.out[1];
	assign OUTPUT_C         = st.out[2];
	assign OUTPUT_D         = st.out[3];
	assign OE_N_A           = st.oe_n[0];
	assign OE_N_B           = st.oe_n[1];
	assign OE_N_C           = st.oe_n[2];
	assign OE_N_D           = st.oe_n[3];

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	sequence low_trip_seen;
		st.sd_src_en[0] && !st.sd_sample[0];
	endsequence

	sequence timer_trip_seen;
		st.sd_src_en[7] && st.sd_sample[7];
	endsequence

	sequence quiet_manual;
		st.sd_flag && !st.auto_restart && !sd_req && !wr_ctrl;
	endsequence

	shut_enter_a: assert property (
		low_trip_seen |=> SHUTDOWN ##1 shut_out)
		else $error("low shutdown source did not shut down");
	timer_high_a: assert property (
		timer_trip_seen |=> SHUTDOWN)
		else $error("timer shutdown source did not shut down");
	timer_idle_a: assert property (
		(st.sd_src_en == 8'h80 && !st.sd_sample[7] && !st.sd_flag
			&& !wr_ctrl) |=> !SHUTDOWN)
		else $error("timer source low caused shutdown");
	status_read_a: assert property (
		(RD && ADDR == eess_pkg::ADDR_SD_CTRL)
		|=> RDATA[7] == $past(st.sd_flag) && RDATA[1:0] == 2'b00)
		else $error("status bit read wrong");
	manual_hold_a: assert property (
		quiet_manual |=> SHUTDOWN)
		else $error("shutdown left without software clear");
	auto_clear_a: assert property (
		(st.sd_flag && st.auto_restart && !sd_req && !wr_ctrl)
		|=> !SHUTDOWN)
		else $error("auto restart did not clear shutdown");
	override_high_a: assert property (
		(shut_out && st.ovr_bd == eess_pkg::OVR_HIGH)
		|=> OUTPUT_B && OUTPUT_D && !OE_N_B && !OE_N_D)
		else $error("B/D not driven high in shutdown");
	override_tri_a: assert property (
		(shut_out && st.ovr_ac == eess_pkg::OVR_TRISTATE)
		|=> OE_N_A && OE_N_C)
		else $error("A/C not released in shutdown");
	inactive_pol_a: assert property (
		(shut_out && st.ovr_bd == eess_pkg::OVR_INACTIVE)
		|=> OUTPUT_D == $past(st.polarity[3]) && !OE_N_D)
		else $error("D not at inactive level in shutdown");
	exit_start_a: assert property (
		(!st.sd_flag && st.override_active && start_hit && !sd_req
			&& !wr_ctrl) |=> !shut_out)
		else $error("override not left at start event");
	run_polarity_a: assert property (
		!shut_out |=> PRIMARY_OUTPUT_A == ($past(WAVE[0])
			^ $past(st.polarity[0])) && !OE_N_A)
		else $error("A waveform polarity wrong");
	sample_once_a: assert property (
		(st.start_en == 16'h0001 && st.start_mode == 16'h0001
			&& $past(st.start_en) == 16'h0001
			&& $past(st.start_mode) == 16'h0001)
		##0 START_DLY_REQ |=> !START_DLY_REQ)
		else $error("single transition gave two events");
endmodule

// ==== common/eess_pkg.sv ====
package eess_pkg;

	localparam int SRC_COUNT = 16;
	localparam int SD_COUNT  = 8;

	localparam logic [3:0] ADDR_START_EN_LO   = 4'h0;
	localparam logic [3:0] ADDR_START_EN_HI   = 4'h1;
	localparam logic [3:0] ADDR_START_MODE_LO = 4'h2;
	localparam logic [3:0] ADDR_START_MODE_HI = 4'h3;
	localparam logic [3:0] ADDR_END_EN_LO     = 4'h4;
	localparam logic [3:0] ADDR_END_EN_HI     = 4'h5;
	localparam logic [3:0] ADDR_END_MODE_LO   = 4'h6;
	localparam logic [3:0] ADDR_END_MODE_HI   = 4'h7;
	localparam logic [3:0] ADDR_SD_CTRL       = 4'h8;
	localparam logic [3:0] ADDR_SD_SRC_EN     = 4'h9;
	localparam logic [3:0] ADDR_POLARITY      = 4'hA;

	localparam int SD_FLAG_BIT    = 7;
	localparam int SD_RESTART_BIT = 6;
	localparam int SD_BD_LSB      = 4;
	localparam int SD_AC_LSB      = 2;

	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [15:0] RST_WORD    = 16'h0000;
	localparam logic [1:0]  RST_OVR_BD  = 2'h1;
	localparam logic [1:0]  RST_OVR_AC  = 2'h1;
	localparam logic [3:0]  RST_POL     = 4'h0;

	localparam logic [1:0] OVR_HIGH     = 2'h3;
	localparam logic [1:0] OVR_LOW      = 2'h2;
	localparam logic [1:0] OVR_TRISTATE = 2'h1;
	localparam logic [1:0] OVR_INACTIVE = 2'h0;

	// Timer sources trip on high, all others on low
	localparam logic [7:0] SD_HIGH_ACTIVE = 8'hC0;

	typedef struct packed {
		logic [15:0] cur;
		logic [15:0] prev;
		logic        edge_hit;
		logic        level_hit;
	} eess_det_state_type;

	typedef struct packed {
		logic [15:0] start_en;
		logic [15:0] start_mode;
		logic [15:0] end_en;
		logic [15:0] end_mode;
		logic        sd_flag;
		logic        auto_restart;
		logic [1:0]  ovr_bd;
		logic [1:0]  ovr_ac;
		logic [7:0]  sd_src_en;
		logic [3:0]  polarity;
		logic        override_active;
		logic [7:0]  sd_sample;
		logic [7:0]  rdata;
		logic [3:0]  out;
		logic [3:0]  oe_n;
	} eess_top_state_type;

endpackage

// ==== common/eess_evt_if.sv ====
`timescale 1ns/1ps
interface eess_evt_if;
	logic [15:0] enable;
	logic [15:0] mode;
	logic [15:0] src;
	logic        edge_hit;
	logic        level_hit;

	modport det (
		input  enable,
		input  mode,
		input  src,
		output edge_hit,
		output level_hit
	);
	modport ctl (
		output enable,
		output mode,
		output src,
		input  edge_hit,
		input  level_hit
	);
endinterface

// ==== design/eess_event_detect.sv ====
`timescale 1ns/1ps
module eess_event_detect #(
	parameter bit ACTIVE = 1'b1
) (
	input wire logic   clk,
	input wire logic   reset,
	eess_evt_if.det    io
);
	eess_pkg::eess_det_state_type st;
	eess_pkg::eess_det_state_type next_st;
	logic [15:0]                  act_now;
	logic [15:0]                  act_before;

	// Sources are resampled so one transition gives one event
	assign act_now    = ACTIVE ? st.cur : ~st.cur;
	assign act_before = ACTIVE ? st.prev : ~st.prev;

	always_comb begin
		next_st      = st;
		next_st.cur  = io.src;
		next_st.prev = st.cur;
		// All enabled sources act together, disabled ones never
		next_st.edge_hit  = |(io.enable & io.mode & act_now
			& ~act_before);
		next_st.level_hit = |(io.enable & ~io.mode
			& act_now);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign io.edge_hit  = st.edge_hit;
	assign io.level_hit = st.level_hit;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence src0_turns_active;
		(st.cur[0] != ACTIVE) ##1 (st.cur[0] == ACTIVE);
	endsequence

	edge_fires_a: assert property (
		src0_turns_active ##0 (io.enable[0] && io.mode[0])
		|=> io.edge_hit)
		else $error("edge on source 0 gave no event");
	// Other sources may legally fire on the next cycle, so only source 0 as the lone
	// enabled edge source is checked for a repeat
	edge_once_a: assert property (
		(io.edge_hit && (io.enable & io.mode) == 16'h0001
			&& $past((io.enable & io.mode) == 16'h0001))
		|=> !io.edge_hit)
		else $error("edge event repeated");
	level_fires_a: assert property (
		(io.enable[0] && !io.mode[0] && st.cur[0] == ACTIVE)
		|=> io.level_hit)
		else $error("level on source 0 gave no event");
	disabled_quiet_a: assert property (
		(io.enable == 16'h0000) |=> !io.edge_hit && !io.level_hit)
		else $error("event from disabled sources");
endmodule

// ==== testbench/eess_src_model.sv ====
`timescale 1ns/1ps
module eess_src_model (
	output logic [15:0] evt,
	output logic [7:0]  sd
);
	// Bit 0 pin, 1-4 comparators, 5 logic cell, 6-7 timers
	// Idle holds low-trip sources high and timer sources low
	initial begin
		evt = 16'h0000;
		sd  = 8'h3F;
	end
	// Callers drive right after a rising edge, so levels never race it
	task drive_evt(input logic [15:0] v);
		evt <= v;
	endtask
	task drive_sd(input logic [7:0] v);
		sd <= v;
	endtask
endmodule

// ==== testbench/edge_event_select_and_shutdown_bench.sv ====
`timescale 1ns/1ps
module edge_event_select_and_shutdown_bench;
	typedef struct {
		int         due;
		int         sel;
		logic [7:0] val;
		logic [7:0] msk;
	} eess_note_type;
	localparam logic [7:0] SD_IDLE = 8'h3F;
	logic        CLK   = 1'b0;
	logic        RESET = 1'b1;
	logic [3:0]  ADDR  = 4'h0;
	logic [7:0]  WDATA = 8'h00;
	logic        WR    = 1'b0;
	logic        RD    = 1'b0;
	logic [3:0]  WAVE  = 4'h0;
	wire logic [7:0]  RDATA;
	wire logic [15:0] evt;
	wire logic [7:0]  sd;
	wire logic        START_IMM, START_DLY_REQ, END_IMM, END_DLY_REQ;
	wire logic        SHUTDOWN, PRIMARY_OUTPUT_A, OUTPUT_B, OUTPUT_C;
	wire logic        OUTPUT_D, OE_N_A, OE_N_B, OE_N_C, OE_N_D;
	eess_note_type q[$];
	eess_note_type it;
	logic [7:0]  seen;
	logic [7:0]  regv [16];
	logic [7:0]  wv;
	logic [1:0]  bd, ac;
	logic [3:0]  pol;
	logic        rs;
	logic [15:0] b;
	int          cyc = 0, cycles = 0, fail_count = 0, checks_done = 0;

	always #25 CLK = ~CLK;

	eess_src_model src (.evt(evt), .sd(sd));
	eess_top dut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .EVENT_SRC(evt),
		.SHUTDOWN_SRC(sd), .WAVE(WAVE), .START_IMM(START_IMM),
		.START_DLY_REQ(START_DLY_REQ), .END_IMM(END_IMM),
		.END_DLY_REQ(END_DLY_REQ), .SHUTDOWN(SHUTDOWN),
		.PRIMARY_OUTPUT_A(PRIMARY_OUTPUT_A), .OUTPUT_B(OUTPUT_B),
		.OUTPUT_C(OUTPUT_C), .OUTPUT_D(OUTPUT_D), .OE_N_A(OE_N_A),
		.OE_N_B(OE_N_B), .OE_N_C(OE_N_C), .OE_N_D(OE_N_D));

	task test_done;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task check(input logic [7:0] got, input logic [7:0] exp, input int sel);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: view %0d got %h want %h",
				$time, sel, got, exp);
		end
	endtask

	// Offsets count negedges from the edge that launched the stimulus
	task note(input int off, input int sel, input logic [7:0] v,
		input logic [7:0] m);
		q.push_back('{cyc + off, sel, v, m});
	endtask
	task ev(input int off, input logic [3:0] v);
		note(off, 1, {4'h0, v}, 8'hFF);
	endtask
	task shut(input int off, input logic v);
		note(off, 3, {7'h00, v}, 8'hFF);
	endtask
	function automatic logic [1:0] pin(input logic [1:0] c,
		input logic w, input logic p, input logic s);
		if (!s) return {1'b0, w ^ p};
		case (c)
			eess_pkg::OVR_HIGH:     return 2'b01;
			eess_pkg::OVR_LOW:      return 2'b00;
			eess_pkg::OVR_TRISTATE: return 2'b10;
			default:                return {1'b0, p};
		endcase
	endfunction
	// A tri-stated pin has no defined level, so its data bit is masked
	task pins(input int off, input logic s);
		logic [7:0] v;
		logic [7:0] m;
		logic [1:0] r;
		m = 8'hFF;
		for (int k = 0; k < 4; k++) begin
			r = pin(k[0] ? bd : ac, WAVE[k], pol[k], s);
			v[k + 4] = r[1];
			v[k] = r[0];
			m[k] = ~r[1];
		end
		note(off, 2, v, m);
	endtask

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLK);
		ADDR  <= a;
		WDATA <= d;
		WR    <= 1'b1;
		@(posedge CLK);
		WR    <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge CLK);
		ADDR <= a;
		RD   <= 1'b1;
		note(2, 0, exp, 8'hFF);
		@(posedge CLK);
		RD   <= 1'b0;
	endtask
	task wr16(input logic [3:0] base, input logic [15:0] v);
		wr(base, v[7:0]);
		wr(base + 4'h1, v[15:8]);
	endtask
	task idle(input int k);
		repeat (k) @(posedge CLK);
	endtask

	always @(negedge CLK) begin
		cyc++;
		while (q.size() > 0 && q[0].due <= cyc) begin
			it = q.pop_front();
			case (it.sel)
				0: seen = RDATA;
				1: seen = {4'h0, START_IMM, START_DLY_REQ, END_IMM,
					END_DLY_REQ};
				2: seen = {OE_N_D, OE_N_C, OE_N_B, OE_N_A, OUTPUT_D,
					OUTPUT_C, OUTPUT_B, PRIMARY_OUTPUT_A};
				default: seen = {7'h00, SHUTDOWN};
			endcase
			check(seen & it.msk, it.val & it.msk, it.sel);
		end
	end

	// Whole run needs well under a thousand cycles
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			test_done();
		end
	end

	initial begin
		wv = 8'($urandom(3));
		repeat (8) @(posedge CLK);
		RESET <= 1'b0;
		for (int a = 0; a < 16; a++) begin
			rd(a[3:0], a == 8 ? {2'b00, eess_pkg::RST_OVR_BD,
				eess_pkg::RST_OVR_AC, 2'b00} : eess_pkg::RST_BYTE);
		end
		// Status bit kept clear here; idle sources never trip
		for (int a = 0; a < 16; a++) begin
			wv = 8'($urandom);
			wr(a[3:0], a == 8 ? {1'b0, wv[6:0]} : wv);
			regv[a] = a < 8 || a == 9 ? wv : a == 10 ? {4'h0, wv[3:0]} :
				a == 8 ? {2'b00, wv[5:2], 2'b00} : 8'h00;
			if (a == 8) regv[a][6] = wv[6];
		end
		for (int a = 0; a < 16; a++) rd(a[3:0], regv[a]);
		for (int a = 0; a < 11; a++) wr(a[3:0], 8'h00);
		for (int j = 0; j < 4; j++) begin
			// Source 0 always gets one pass so its edge checks are reached
			b = 16'h0001 << (j == 0 ? 15 : j == 1 ? 0 : $urandom % 16);
			wr16(eess_pkg::ADDR_START_EN_LO, b);
			wr16(eess_pkg::ADDR_START_MODE_LO, b);
			wr16(eess_pkg::ADDR_END_EN_LO, b);
			wr16(eess_pkg::ADDR_END_MODE_LO, b);
			idle(4);
			src.drive_evt(b);
			ev(3, 4'b0100);
			ev(4, 4'b0000);
			idle(5);
			src.drive_evt(16'h0000);
			ev(3, 4'b0001);
			ev(4, 4'b0000);
			wr16(eess_pkg::ADDR_START_MODE_LO, 16'h0000);
			wr16(eess_pkg::ADDR_END_MODE_LO, 16'h0000);
			idle(4);
			ev(1, 4'b0010);
			src.drive_evt(b);
			ev(3, 4'b1000);
			idle(5);
			wr16(eess_pkg::ADDR_START_EN_LO, 16'h0000);
			wr16(eess_pkg::ADDR_END_EN_LO, 16'h0000);
			wr16(eess_pkg::ADDR_START_MODE_LO, b);
			idle(4);
			src.drive_evt(16'h0000);
			ev(3, 4'b0000);
			idle(3);
			src.drive_evt(b);
			ev(3, 4'b0000);
			idle(5);
			src.drive_evt(16'h0000);
		end
		for (int i = 0; i < 8; i++) begin
			bd  = 2'(i % 4);
			ac  = 2'(3 - i % 4);
			rs  = i[0];
			pol = 4'($urandom);
			WAVE <= 4'($urandom);
			wr(eess_pkg::ADDR_POLARITY, {4'h0, pol});
			wr16(eess_pkg::ADDR_START_EN_LO, 16'h0001);
			wr16(eess_pkg::ADDR_START_MODE_LO, 16'h0000);
			wr(eess_pkg::ADDR_SD_CTRL, {1'b0, rs, bd, ac, 2'b00});
			wr(eess_pkg::ADDR_SD_SRC_EN, 8'h01 << i);
			idle(4);
			pins(1, 1'b0);
			src.drive_sd(SD_IDLE ^ (8'h01 << ((i + 1) % 8)));
			shut(3, 1'b0);
			idle(4);
			src.drive_sd(SD_IDLE ^ (8'h01 << i));
			shut(3, 1'b1);
			pins(4, 1'b1);
			idle(4);
			rd(eess_pkg::ADDR_SD_CTRL, {1'b1, rs, bd, ac, 2'b00});
			src.drive_sd(SD_IDLE);
			shut(5, ~rs);
			pins(5, 1'b1);
			if (!rs) begin
				idle(4);
				wr(eess_pkg::ADDR_SD_CTRL, {1'b0, rs, bd, ac, 2'b00});
				shut(3, 1'b0);
				pins(3, 1'b1);
			end
			idle(4);
			src.drive_evt(16'h0001);
			pins(5, 1'b0);
			idle(6);
			src.drive_evt(16'h0000);
		end
		// A live trip outlasts a software clear; bit 7 also forces shutdown
		src.drive_sd(SD_IDLE ^ 8'h80);
		idle(4);
		wr(eess_pkg::ADDR_SD_CTRL, 8'h00);
		shut(1, 1'b1);
		src.drive_sd(SD_IDLE);
		idle(4);
		shut(1, 1'b1);
		wr(eess_pkg::ADDR_SD_CTRL, 8'h00);
		shut(1, 1'b0);
		wr(eess_pkg::ADDR_SD_CTRL, 8'h80);
		shut(1, 1'b1);
		wr(eess_pkg::ADDR_SD_CTRL, 8'h00);
		shut(1, 1'b0);
		idle(8);
		test_done();
	end
endmodule
